// File: bench/tb.sv
`default_nettype none
module tb
  import uecr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end

  logic        i_mclk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [8:0]  adr = '0;
  logic [31:0] wdat = '0;
  logic [3:0]  bsts;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic        o_irq;
  logic [2:0]  in_ready, in_stall, in_nak, tx_tgl;
  logic [4:0]  l0, l1;
  logic [6:0]  l2, n, sz, b;
  logic [1:0]  mode;
  logic        usb_rst, done, xin, bufr;
  logic [4:0]  evt;
  logic [1:0]  xep, pid;
  logic [6:0]  xbytes;
  logic [2:0]  rx_tgl;
  logic [5:0]  rx_st;
  logic [4:0]  m0, m1;
  logic [6:0]  m2, da;
  logic        frc;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp;
  logic [7:0]  v[6];
  logic [6:0]  cidx[6] = '{IDX_EP0_RXC, IDX_EP0_TXC, IDX_EP1_RXC,
                           IDX_EP1_TXC, IDX_EP2_RXC, IDX_EP2_TXC};
  int          errors = 0;
  int          tests_run = 0;
  integer      seed = 32'h10DD;

  always #25 i_mclk = ~i_mclk;
  initial bsts = 4'($random(seed));

  uecr_top dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(cyc),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_irq(o_irq), .i_usb_reset(usb_rst), .i_sie_evt(evt),
    .i_xfer_done(done), .i_xfer_ep(xep), .i_xfer_in(xin), .i_xfer_pid(pid),
    .i_xfer_bytes(xbytes), .i_ep2_buf_ready(bufr), .i_buf_status(bsts),
    .o_in_ready(in_ready), .o_in_stall(in_stall), .o_in_nak(in_nak), .o_tx_toggle(tx_tgl),
    .o_rx_toggle(rx_tgl), .o_rx_stat(rx_st), .o_ep0_tx_len(l0), .o_ep1_tx_len(l1),
    .o_ep2_tx_len(l2), .o_ep0_rx_max(m0), .o_ep1_rx_max(m1), .o_ep2_rx_max(m2),
    .o_ep2_xfer_mode(mode), .o_dev_addr(da), .o_bus_reset(frc));

  uecr_host_model host_u (.i_mclk(i_mclk), .o_usb_reset(usb_rst), .o_sie_evt(evt),
    .o_xfer_done(done), .o_xfer_ep(xep), .o_xfer_in(xin), .o_xfer_pid(pid),
    .o_xfer_bytes(xbytes), .o_buf_ready(bufr));

  // ------------------------------------------------------------
  // Register bus master and read scoreboard
  // ------------------------------------------------------------
  task automatic wb(input logic w, input logic [6:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge i_mclk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin @(posedge i_mclk); k++; end while (o_wb_ack !== 1'b1 && k < 50);
    cyc <= 1'b0;
    if (k >= 50) begin errors++; $display("[ERR] wb_ack exp=1 got=0"); end
  endtask

  task automatic rd(input logic [6:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    wb(1'b0, idx, 8'h00);
  endtask

  always @(posedge i_mclk) begin
    if (o_wb_ack === 1'b1 && !we) begin
      exp = exp_q.pop_front();
      `CHK("rdata", {24'h0, exp}, o_wb_dat)
    end
  end

  task automatic print_verdict;
    $display("Checks run %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    for (logic [7:0] i = 8'h30; i < 8'h49; i++)
      rd(i[6:0], (i == 8'h32) ? CTL_RESET : (i == 8'h47) ? {4'h0, bsts} : 8'h00);
    for (int k = 0; k < 6; k++) begin
      v[k] = 8'($random(seed)) & ((k > 3) ? 8'h7F : 8'h1F);
      wb(1'b1, cidx[k], v[k] | ((k > 3) ? 8'h80 : 8'hE0));
      rd(cidx[k], v[k]);
    end
    `CHK("tx_len", {v[1][4:0], v[3][4:0], v[5][6:0]}, {l0, l1, l2})
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, IDX_EP2_TX, 8'hF0 | 8'(s));
      rd(IDX_EP2_TX, 8'(s));
      `CHK("in_dec", {s == 3, s == 1, s == 2}, {in_ready[2], in_stall[2], in_nak[2]})
    end
    // A correct IN on endpoint 2 raises the flag, flips the toggle and parks on NAK.
    wb(1'b1, IDX_IRQ_MASK, 8'h80);
    wb(1'b1, IDX_EP2_TX, {6'h0, ST_VALID});
    host_u.xfer(2'd2, 1'b1, 7'h00);
    rd(IDX_EP2_TX, 8'h0E);
    `CHK("irq", 1'b1, o_irq)
    `CHK("tx_tgl", 1'b1, tx_tgl[2])
    wb(1'b1, IDX_EP2_TX, 8'h06);
    rd(IDX_EP2_TX, 8'h06);
    wb(1'b1, IDX_EP2_TX, 8'h02);
    rd(IDX_EP2_TX, 8'h02);
    `CHK("tx_tgl", 1'b0, tx_tgl[2])
    wb(1'b1, IDX_IRQ_STAT, 8'h80);
    host_u.pulse(3'h1);
    rd(IDX_IRQ_STAT, 8'h01);
    `CHK("irq", 1'b0, o_irq)
    wb(1'b1, IDX_IRQ_MASK, 8'h81);
    rd(IDX_IRQ_MASK, 8'h81);
    `CHK("irq", 1'b1, o_irq)
    wb(1'b1, IDX_IRQ_STAT, 8'h01);
    rd(IDX_IRQ_STAT, 8'h00);
    `CHK("irq", 1'b0, o_irq)
    // Receive counters keep what is left of the loaded size.
    for (int e = 0; e < 3; e++) begin
      n  = (e == 2) ? 7'h7F : 7'h1F;
      sz = 7'(1 + $unsigned($random(seed)) % n);
      b  = 7'($unsigned($random(seed)) % (sz + 1));
      wb(1'b1, cidx[2 * e], {1'b0, sz});
      host_u.xfer(2'(e), 1'b0, b);
      rd(cidx[2 * e], {1'b0, sz - b});
      `CHK("rx_max", sz - b, (e == 2) ? m2 : (e == 1) ? {2'b00, m1} : {2'b00, m0})
    end
    `CHK("rx_tgl", 3'h7, rx_tgl)
    `CHK("rx_stat", 6'h2A, rx_st)
    `CHK("irq", 1'b1, o_irq)
    v[0] = 8'($random(seed));
    wb(1'b1, IDX_DEV_ADDR, v[0]);
    rd(IDX_DEV_ADDR, v[0] & 8'h7F);
    `CHK("dev_addr", v[0][6:0], da)
    wb(1'b1, IDX_IRQ_STAT, 8'hFF);
    wb(1'b1, IDX_EP2_TX, {6'h0, ST_NAK});
    wb(1'b1, IDX_EP2_RX, 8'h40);
    `CHK("mode", XM_UPLOAD, mode)
    wb(1'b1, IDX_EP2_TX, {6'h0, ST_STALL});
    rd(IDX_EP2_TX, {6'h0, ST_NAK});
    host_u.pulse(3'h4);
    rd(IDX_EP2_TX, {6'h0, ST_VALID});
    host_u.xfer(2'd2, 1'b1, 7'h00);
    rd(IDX_IRQ_STAT, 8'h00);
    `CHK("irq", 1'b0, o_irq)
    wb(1'b1, IDX_EP2_RX, 8'h00);
    // Both kinds of bus reset clear toggle and status of endpoint 2 transmit.
    wb(1'b1, IDX_EP2_TX, 8'h07);
    host_u.pulse(3'h2);
    rd(IDX_EP2_TX, 8'h00);
    rd(IDX_IRQ_STAT, 8'h02);
    wb(1'b1, IDX_EP2_TX, 8'h07);
    wb(1'b1, IDX_CONTROL, 8'h07);
    `CHK("force", 1'b1, frc)
    wb(1'b1, IDX_CONTROL, 8'h06);
    `CHK("force", 1'b0, frc)
    rd(IDX_EP2_TX, 8'h00);
    // A second reset in mid-run must bring control, interrupt status and transmit lengths back to their reset values.
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd(IDX_CONTROL, CTL_RESET);
    rd(IDX_IRQ_STAT, 8'h00);
    `CHK("tx_len", 17'h0, {l0, l1, l2})
    `CHK("irq", 1'b0, o_irq)
    repeat (2) @(posedge i_mclk);
    print_verdict();
  end
`undef CHK
endmodule
`default_nettype wire

// File: bench/uecr_host_model.sv
`default_nettype none
module uecr_host_model (
  input  wire logic       i_mclk,
  output logic            o_usb_reset,
  output logic [4:0]      o_sie_evt,
  output logic            o_xfer_done,
  output logic [1:0]      o_xfer_ep,
  output logic            o_xfer_in,
  output logic [1:0]      o_xfer_pid,
  output logic [6:0]      o_xfer_bytes,
  output logic            o_buf_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {o_usb_reset, o_sie_evt, o_xfer_done, o_buf_ready} = '0;
    {o_xfer_ep, o_xfer_in, o_xfer_pid, o_xfer_bytes} = '0;
  end

  // ------------------------------------------------------------
  // Transaction reporting
  // ------------------------------------------------------------
  task automatic xfer(input logic [1:0] ep, input logic in, input logic [6:0] n);
    @(posedge i_mclk);
    o_xfer_done  <= 1'b1;
    o_xfer_ep    <= ep;
    o_xfer_in    <= in;
    o_xfer_pid   <= {1'b1, in};
    o_xfer_bytes <= n;
    @(posedge i_mclk);
    o_xfer_done  <= 1'b0;
    // Endpoint, direction and byte count are scrambled after the pulse so stale values cannot pass.
    o_xfer_ep    <= ~ep;
    o_xfer_in    <= ~in;
    o_xfer_bytes <= ~n;
  endtask

  // Bit 2 marks new buffer data, bit 1 a bus reset, bit 0 a frame start.
  task automatic pulse(input logic [2:0] w);
    @(posedge i_mclk);
    {o_buf_ready, o_usb_reset, o_sie_evt[0]} <= w;
    @(posedge i_mclk);
    {o_buf_ready, o_usb_reset, o_sie_evt[0]} <= 3'h0;
  endtask
endmodule
`default_nettype wire

// File: rtl/uecr_pkg.sv
`default_nettype none
package uecr_pkg;

  // ---------------------------------------------------------------
  // Bus geometry and register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam int unsigned WB_AW = 9;
  localparam int unsigned WB_DW = 32;

  localparam logic [6:0] IDX_IRQ_STAT = 7'h30;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h31;
  localparam logic [6:0] IDX_CONTROL  = 7'h32;
  localparam logic [6:0] IDX_DEV_ADDR = 7'h33;
  localparam logic [6:0] IDX_LAST_ST  = 7'h34;
  localparam logic [6:0] IDX_EP0_CTL  = 7'h35;
  localparam logic [6:0] IDX_EP0_RXC  = 7'h36;
  localparam logic [6:0] IDX_EP0_TXC  = 7'h37;
  localparam logic [6:0] IDX_EP1_RX   = 7'h38;
  localparam logic [6:0] IDX_EP1_RXC  = 7'h39;
  localparam logic [6:0] IDX_EP1_TX   = 7'h3A;
  localparam logic [6:0] IDX_EP1_TXC  = 7'h3B;
  localparam logic [6:0] IDX_EP2_RX   = 7'h3C;
  localparam logic [6:0] IDX_EP2_RXC  = 7'h3D;
  localparam logic [6:0] IDX_EP2_TX   = 7'h3E;
  localparam logic [6:0] IDX_EP2_TXC  = 7'h3F;
  localparam logic [6:0] IDX_BUF_ST   = 7'h47;

  // ---------------------------------------------------------------
  // Field encodings and positions
  // ---------------------------------------------------------------
  localparam logic [1:0] ST_DISABLED = 2'h0;
  localparam logic [1:0] ST_STALL    = 2'h1;
  localparam logic [1:0] ST_NAK      = 2'h2;
  localparam logic [1:0] ST_VALID    = 2'h3;

  localparam logic [1:0] XM_NORMAL   = 2'h0;
  localparam logic [1:0] XM_UPLOAD   = 2'h1;
  localparam logic [1:0] XM_DOWNLOAD = 2'h2;

  localparam int unsigned EP_FLAG    = 3;
  localparam int unsigned EP_TGL     = 2;
  localparam int unsigned EP0_FLAG   = 7;
  localparam int unsigned EP0_TX_TGL = 6;
  localparam int unsigned IRQ_DONE   = 7;
  localparam int unsigned IRQ_RST    = 1;
  localparam int unsigned CTL_FORCE  = 0;

  localparam logic [7:0] IRQ_WMASK   = 8'hBF;
  localparam logic [7:0] CTL_WMASK   = 8'hCF;
  localparam logic [7:0] CTL_RESET   = 8'h06;
  localparam logic [7:0] EP0_RST_KEEP = 8'h88;

endpackage
`default_nettype wire

// File: rtl/uecr_top.sv
// Contract
// - A received or software-forced bus reset clears toggle and status of endpoint 2 transmit.
// - A correct endpoint 2 transmission sets its done flag, which software clears.
// - The transmit toggle names the data PID of the next packet, 0 for DATA0, 1 for DATA1.
// - Toggles flip in hardware on a relevant transfer and may also be written by software.
// - Transmit status 00 disables, 01 stalls, 10 naks and 11 enables IN answers.
// - Hardware forces a status field to NAK after a correct transfer on that endpoint.
// - Software writes to endpoint 2 transmit status are ignored in upload mode.
// - Software loads the 5-bit receive counters of endpoints 0 and 1 with the buffer size.
// - After a reception the receive counter holds the loaded size minus bytes received, or zero if more bytes were received.
// - The endpoint 2 receive counter is 7 bits and behaves like the others, except in download mode where only a short packet updates it.
// - Endpoints 0 and 1 send exactly the bytes held in their 5-bit transmit counters.
// - Endpoint 2 sends the bytes held in its 7-bit transmit counter.
// - The endpoint 2 mode selects normal, upload or download operation.
// - In upload mode IN transfers raise no done flag and status returns to valid on new data.
//
// The Wishbone slave port is this design's own decision.
`default_nettype none
module uecr_top
  import uecr_pkg::*;
(
  input  wire logic             i_mclk,
  input  wire logic             i_reset_n,
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [WB_AW-1:0] i_wb_adr,
  input  wire logic [3:0]       i_wb_sel,
  input  wire logic [WB_DW-1:0] i_wb_dat,
  output logic      [WB_DW-1:0] o_wb_dat,
  output logic                  o_wb_ack,
  output logic                  o_irq,
  input  wire logic             i_usb_reset,
  input  wire logic [4:0]       i_sie_evt,
  input  wire logic             i_xfer_done,
  input  wire logic [1:0]       i_xfer_ep,
  input  wire logic             i_xfer_in,
  input  wire logic [1:0]       i_xfer_pid,
  input  wire logic [6:0]       i_xfer_bytes,
  input  wire logic             i_ep2_buf_ready,
  input  wire logic [3:0]       i_buf_status,
  output logic      [2:0]       o_in_ready,
  output logic      [2:0]       o_in_stall,
  output logic      [2:0]       o_in_nak,
  output logic      [2:0]       o_tx_toggle,
  output logic      [2:0]       o_rx_toggle,
  output logic      [5:0]       o_rx_stat,
  output logic      [4:0]       o_ep0_tx_len,
  output logic      [4:0]       o_ep1_tx_len,
  output logic      [6:0]       o_ep2_tx_len,
  output logic      [4:0]       o_ep0_rx_max,
  output logic      [4:0]       o_ep1_rx_max,
  output logic      [6:0]       o_ep2_rx_max,
  output logic      [1:0]       o_ep2_xfer_mode,
  output logic      [6:0]       o_dev_addr,
  output logic                  o_bus_reset
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] ctl;
    logic [6:0] device_address;
    logic [7:0] last_st;
    logic [7:0] ep0;
    logic [4:0] rx0;
    logic [4:0] tx0;
    logic [3:0] ep1rx;
    logic [4:0] rx1;
    logic [3:0] ep1tx;
    logic [4:0] tx1;
    logic [7:0] ep2rx;
    logic [6:0] rx2;
    logic [3:0] ep2tx;
    logic [6:0] tx2;
    logic       ack;
    logic [7:0] rdat;
  } uecr_state_s;

  uecr_state_s r_ff;
  uecr_state_s nxt_r;

  logic       sw_acc;
  logic       sw_wr;
  logic [6:0] sw_idx;
  logic [7:0] sw_dat;
  logic       bus_rst;

  // The bus answers one cycle after the request; the write lands in that
  // same first cycle, which the master cannot observe before ack.
  assign sw_acc  = i_wb_cyc & i_wb_stb & ~r_ff.ack;
  assign sw_wr   = sw_acc & i_wb_we & i_wb_sel[0];
  assign sw_idx  = i_wb_adr[8:2];
  assign sw_dat  = i_wb_dat[7:0];
  assign bus_rst = i_usb_reset | r_ff.ctl[CTL_FORCE];

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] left_after(input logic [6:0] lim,
                                            input logic [6:0] got);
    return (got > lim) ? 7'h00 : 7'(lim - got);
  endfunction

  function automatic logic [2:0] in_answer(input logic [1:0] st);
    return {st == ST_VALID, st == ST_STALL, st == ST_NAK};
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] rv;
    logic [1:0] xm;
    logic       evt_done;
    rv       = 8'h00;
    xm       = r_ff.ep2rx[7:6];
    evt_done = 1'b0;
    nxt_r     = r_ff;
    nxt_r.ack = sw_acc;

    case (sw_idx)
      IDX_IRQ_STAT: rv = r_ff.irq_stat;
      IDX_IRQ_MASK: rv = r_ff.irq_mask;
      IDX_CONTROL:  rv = r_ff.ctl;
      IDX_DEV_ADDR: rv = {1'b0, r_ff.device_address};
      IDX_LAST_ST:  rv = r_ff.last_st;
      IDX_EP0_CTL:  rv = r_ff.ep0;
      IDX_EP0_RXC:  rv = {3'h0, r_ff.rx0};
      IDX_EP0_TXC:  rv = {3'h0, r_ff.tx0};
      IDX_EP1_RX:   rv = {4'h0, r_ff.ep1rx};
      IDX_EP1_RXC:  rv = {3'h0, r_ff.rx1};
      IDX_EP1_TX:   rv = {4'h0, r_ff.ep1tx};
      IDX_EP1_TXC:  rv = {3'h0, r_ff.tx1};
      IDX_EP2_RX:   rv = r_ff.ep2rx;
      IDX_EP2_RXC:  rv = {1'b0, r_ff.rx2};
      IDX_EP2_TX:   rv = {4'h0, r_ff.ep2tx};
      IDX_EP2_TXC:  rv = {1'b0, r_ff.tx2};
      IDX_BUF_ST:   rv = {4'h0, i_buf_status};
      default:      rv = 8'h00;
    endcase
    if (sw_acc && !i_wb_we) begin
      nxt_r.rdat = rv;
    end

    // Software writes; an endpoint done flag is cleared by writing zero to it, an interrupt status bit by writing one.
    if (sw_wr) begin
      case (sw_idx)
        IDX_IRQ_STAT: nxt_r.irq_stat = r_ff.irq_stat & ~(sw_dat & IRQ_WMASK);
        IDX_IRQ_MASK: nxt_r.irq_mask = sw_dat & IRQ_WMASK;
        IDX_CONTROL:  nxt_r.ctl = sw_dat & CTL_WMASK;
        IDX_DEV_ADDR: nxt_r.device_address = sw_dat[6:0];
        IDX_EP0_CTL:  nxt_r.ep0 = {r_ff.ep0[7] & sw_dat[7], sw_dat[6:4], 1'b0, sw_dat[2:0]};
        IDX_EP0_RXC:  nxt_r.rx0 = sw_dat[4:0];
        IDX_EP0_TXC:  nxt_r.tx0 = sw_dat[4:0];
        IDX_EP1_RX:   nxt_r.ep1rx = {r_ff.ep1rx[3] & sw_dat[3], sw_dat[2:0]};
        IDX_EP1_RXC:  nxt_r.rx1 = sw_dat[4:0];
        IDX_EP1_TX:   nxt_r.ep1tx = {r_ff.ep1tx[3] & sw_dat[3], sw_dat[2:0]};
        IDX_EP1_TXC:  nxt_r.tx1 = sw_dat[4:0];
        IDX_EP2_RX: begin
          nxt_r.ep2rx = {sw_dat[7:6], 2'b00, r_ff.ep2rx[3] & sw_dat[3], sw_dat[2:0]};
          if (xm == XM_DOWNLOAD) begin
            nxt_r.ep2rx[1:0] = r_ff.ep2rx[1:0];
          end
        end
        IDX_EP2_RXC:  nxt_r.rx2 = sw_dat[6:0];
        IDX_EP2_TX: begin
          nxt_r.ep2tx = {r_ff.ep2tx[3] & sw_dat[3], sw_dat[2:0]};
          if (xm == XM_UPLOAD) begin
            nxt_r.ep2tx[1:0] = r_ff.ep2tx[1:0];
          end
        end
        IDX_EP2_TXC:  nxt_r.tx2 = sw_dat[6:0];
        default: begin
        end
      endcase
    end

    // Hardware events come after the write so that a set beats a clear.
    if (i_xfer_done) begin
      nxt_r.last_st = {i_xfer_pid, i_xfer_in, i_xfer_ep, 3'h0};
      case (i_xfer_ep)
        2'd0: begin
          evt_done = 1'b1;
          nxt_r.ep0[EP0_FLAG] = 1'b1;
          if (i_xfer_in) begin
            nxt_r.ep0[EP0_TX_TGL] = ~r_ff.ep0[EP0_TX_TGL];
            nxt_r.ep0[5:4] = ST_NAK;
          end else begin
            nxt_r.ep0[EP_TGL] = ~r_ff.ep0[EP_TGL];
            nxt_r.ep0[1:0] = ST_NAK;
            nxt_r.rx0 = 5'(left_after({2'b00, r_ff.rx0}, i_xfer_bytes));
          end
        end
        2'd1: begin
          evt_done = 1'b1;
          if (i_xfer_in) begin
            nxt_r.ep1tx = {1'b1, ~r_ff.ep1tx[EP_TGL], ST_NAK};
          end else begin
            nxt_r.ep1rx = {1'b1, ~r_ff.ep1rx[EP_TGL], ST_NAK};
            nxt_r.rx1 = 5'(left_after({2'b00, r_ff.rx1}, i_xfer_bytes));
          end
        end
        2'd2: begin
          if (i_xfer_in) begin
            nxt_r.ep2tx[EP_TGL] = ~r_ff.ep2tx[EP_TGL];
            nxt_r.ep2tx[1:0] = ST_NAK;
            if (xm != XM_UPLOAD) begin
              evt_done = 1'b1;
              nxt_r.ep2tx[EP_FLAG] = 1'b1;
            end
          end else begin
            nxt_r.ep2rx[EP_TGL] = ~r_ff.ep2rx[EP_TGL];
            nxt_r.ep2rx[1:0] = ST_NAK;
            if (xm != XM_DOWNLOAD) begin
              evt_done = 1'b1;
              nxt_r.ep2rx[EP_FLAG] = 1'b1;
              nxt_r.rx2 = left_after(r_ff.rx2, i_xfer_bytes);
            end else if (i_xfer_bytes < r_ff.rx2) begin
              // A short packet ends the hardware-managed stream.
              evt_done = 1'b1;
              nxt_r.ep2rx[7:6] = XM_NORMAL;
              nxt_r.ep2rx[EP_FLAG] = 1'b1;
              nxt_r.rx2 = left_after(r_ff.rx2, i_xfer_bytes);
            end
          end
        end
        default: begin
        end
      endcase
    end

    // New buffer data re-arms the hardware-managed direction.
    if (i_ep2_buf_ready) begin
      if (xm == XM_UPLOAD && r_ff.ep2tx[1:0] == ST_NAK) begin
        nxt_r.ep2tx[1:0] = ST_VALID;
      end
      if (xm == XM_DOWNLOAD && r_ff.ep2rx[1:0] == ST_NAK) begin
        nxt_r.ep2rx[1:0] = ST_VALID;
      end
    end

    nxt_r.irq_stat = nxt_r.irq_stat
                   | {evt_done, 1'b0, i_sie_evt[4:1], bus_rst, i_sie_evt[0]};

    if (bus_rst) begin
      nxt_r.ep0 = nxt_r.ep0 & EP0_RST_KEEP;
      nxt_r.ep1rx[2:0] = 3'h0;
      nxt_r.ep1tx[2:0] = 3'h0;
      nxt_r.ep2rx[2:0] = 3'h0;
      nxt_r.ep2tx[2:0] = 3'h0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_ff     <= '0;
      r_ff.ctl <= CTL_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic [2:0] ans0;
  logic [2:0] ans1;
  logic [2:0] ans2;

  assign ans0 = in_answer(r_ff.ep0[5:4]);
  assign ans1 = in_answer(r_ff.ep1tx[1:0]);
  assign ans2 = in_answer(r_ff.ep2tx[1:0]);

  assign o_in_ready      = {ans2[2], ans1[2], ans0[2]};
  assign o_in_stall      = {ans2[1], ans1[1], ans0[1]};
  assign o_in_nak        = {ans2[0], ans1[0], ans0[0]};
  assign o_tx_toggle     = {r_ff.ep2tx[EP_TGL], r_ff.ep1tx[EP_TGL], r_ff.ep0[EP0_TX_TGL]};
  assign o_rx_toggle     = {r_ff.ep2rx[EP_TGL], r_ff.ep1rx[EP_TGL], r_ff.ep0[EP_TGL]};
  assign o_rx_stat       = {r_ff.ep2rx[1:0], r_ff.ep1rx[1:0], r_ff.ep0[1:0]};
  assign o_ep0_tx_len    = r_ff.tx0;
  assign o_ep1_tx_len    = r_ff.tx1;
  assign o_ep2_tx_len    = r_ff.tx2;
  assign o_ep0_rx_max    = r_ff.rx0;
  assign o_ep1_rx_max    = r_ff.rx1;
  assign o_ep2_rx_max    = r_ff.rx2;
  assign o_ep2_xfer_mode = r_ff.ep2rx[7:6];
  assign o_dev_addr      = r_ff.device_address;
  assign o_bus_reset     = r_ff.ctl[CTL_FORCE];
  assign o_wb_ack        = r_ff.ack;
  assign o_wb_dat        = {24'h000000, r_ff.rdat};
  assign o_irq           = |(r_ff.irq_stat & r_ff.irq_mask);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  logic ep2_in_evt;
  assign ep2_in_evt = i_xfer_done && i_xfer_ep == 2'd2 && i_xfer_in && !bus_rst;

  property p_bus_rst_clear;
    bus_rst |=> r_ff.ep2tx[2:0] == 3'h0;
  endproperty
  a_bus_rst_clear: assert property (p_bus_rst_clear) else $error("ep2 tx not cleared");

  property p_done_flag;
    ep2_in_evt && r_ff.ep2rx[7:6] == XM_NORMAL |=> r_ff.ep2tx[EP_FLAG];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("ep2 done flag not set");

  property p_force_nak;
    ep2_in_evt |=> r_ff.ep2tx[1:0] == ST_NAK ##1 !o_in_ready[2] || i_ep2_buf_ready
                   || $past(sw_wr);
  endproperty
  a_force_nak: assert property (p_force_nak) else $error("ep2 tx status not nak");

  property p_toggle_flip;
    ep2_in_evt |=> r_ff.ep2tx[EP_TGL] != $past(r_ff.ep2tx[EP_TGL]);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("tx toggle did not flip");

  property p_upload_guard;
    sw_wr && sw_idx == IDX_EP2_TX && r_ff.ep2rx[7:6] == XM_UPLOAD && !i_xfer_done
      && !i_ep2_buf_ready && !bus_rst |=> $stable(r_ff.ep2tx[1:0]);
  endproperty
  a_upload_guard: assert property (p_upload_guard) else $error("upload write hit status");

  property p_upload_silent;
    ep2_in_evt && r_ff.ep2rx[7:6] == XM_UPLOAD && !r_ff.ep2tx[EP_FLAG]
      |=> !r_ff.ep2tx[EP_FLAG];
  endproperty
  a_upload_silent: assert property (p_upload_silent) else $error("upload raised flag");

  property p_rx_left;
    i_xfer_done && i_xfer_ep == 2'd1 && !i_xfer_in && !bus_rst
      && i_xfer_bytes <= {2'b00, r_ff.rx1}
      |=> r_ff.rx1 == 5'($past(r_ff.rx1) - $past(i_xfer_bytes[4:0]));
  endproperty
  a_rx_left: assert property (p_rx_left) else $error("rx counter remainder wrong");

  property p_tx2_len;
    sw_wr && sw_idx == IDX_EP2_TXC |=> o_ep2_tx_len == $past(i_wb_dat[6:0]);
  endproperty
  a_tx2_len: assert property (p_tx2_len) else $error("ep2 tx length not loaded");

  property p_zero_bits;
    sw_acc && !i_wb_we && sw_idx == IDX_EP2_TX |=> o_wb_ack && o_wb_dat[7:4] == 4'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("reserved bits read nonzero");

  property p_stall_decode;
    r_ff.ep2tx[1:0] == ST_STALL |-> o_in_stall[2] && !o_in_ready[2] && !o_in_nak[2];
  endproperty
  a_stall_decode: assert property (p_stall_decode) else $error("stall decode wrong");

  property p_irq_raise;
    i_xfer_done && i_xfer_ep == 2'd0 && r_ff.irq_mask[IRQ_DONE] && !sw_wr |=> o_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

  property p_cov_in_done;
    ep2_in_evt ##1 r_ff.ep2tx[EP_FLAG];
  endproperty
  c_in_done: cover property (p_cov_in_done);

  property p_cov_upload_rearm;
    r_ff.ep2rx[7:6] == XM_UPLOAD ##0 i_ep2_buf_ready ##1 o_in_ready[2];
  endproperty
  c_upload_rearm: cover property (p_cov_upload_rearm);

  property p_cov_force_reset;
    sw_wr && sw_idx == IDX_CONTROL && sw_dat[CTL_FORCE] ##1 o_bus_reset;
  endproperty
  c_force_reset: cover property (p_cov_force_reset);

endmodule
`default_nettype wire
